// File: cteq_defines.vh
`ifndef CTEQ_DEFINES_VH
`define CTEQ_DEFINES_VH
// Register offsets (16-bit registers, word index on a plain port)
`define CTEQ_ADDR_W          5
`define CTEQ_REG_DEPTH_CFG   5'h00
`define CTEQ_REG_CONTROL     5'h01
`define CTEQ_REG_STATUS      5'h02
`define CTEQ_REG_EVQ_UA_HI   5'h03
`define CTEQ_REG_EVQ_UA_LO   5'h04
`define CTEQ_REG_MODE        5'h05
`define CTEQ_REG_MQ_DIR      5'h06
`define CTEQ_REG_MQ_UA_BASE  5'h08
// Field positions
`define CTEQ_DEPTH_LSB       8
`define CTEQ_DEPTH_MSB       12
`define CTEQ_RESET_BIT       10
`define CTEQ_TAIL_INC_BIT    8
`define CTEQ_TS_EN_BIT       5
`define CTEQ_OVF_BIT         3
`define CTEQ_FULL_BIT        2
`define CTEQ_HALF_BIT        1
`define CTEQ_NE_BIT          0
// Modes and reset values
`define CTEQ_MODE_CONFIG     3'h4
`define CTEQ_MODE_RESET      3'h4
`define CTEQ_DEPTH_RESET     5'h00
`define CTEQ_IE_RESET        4'h0
`endif

// File: cteq_top.v
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/100ps
`include "cteq_defines.vh"

module cteq_top #(
    parameter EVQ_BASE    = 32'h0000_0400,
    parameter EVQ_STRIDE  = 32'h0000_0010,
    parameter EVQ_TS_XTRA = 32'h0000_0004,
    parameter MQ_COUNT    = 7
) (
    input  wire                    ref_clk_i,
    input  wire                    sys_rst_i,
    input  wire [`CTEQ_ADDR_W-1:0] reg_addr_i,
    input  wire [15:0]             reg_wdata_i,
    input  wire                    reg_wr_i,
    input  wire                    reg_rd_i,
    output reg  [15:0]             reg_rdata_o,
    input  wire                    tx_done_log_i,
    input  wire [31:0]             mq_head_addr_i,
    input  wire [31:0]             mq_tail_addr_i,
    output wire [2:0]              mq_sel_o,
    output reg  [2:0]              controller_operating_mode_o,
    output reg                     event_timestamp_enable_o,
    output reg                     evq_write_stb_o,
    output reg  [31:0]             evq_write_addr_o,
    output reg                     evq_irq_o
);
    reg [4:0]  queue_depth_field_r;
    reg        event_timestamp_enable_r;
    reg [3:0]  irq_enable_r;
    reg        event_overflow_flag_r;
    reg        queue_reset_request_r;
    reg [2:0]  mode_r;
    reg [MQ_COUNT-1:0] queue_direction_select_r;
    reg [4:0]  head_r;
    reg [4:0]  tail_r;
    reg [5:0]  count_r;
    reg [2:0]  mq_sel_r;

    wire [5:0]  depth_entries   = {1'b0, queue_depth_field_r} + 6'h01;
    wire        in_config       = (mode_r == `CTEQ_MODE_CONFIG);
    wire        event_full_flag     = (count_r == depth_entries);
    wire        event_half_flag     = ({count_r, 1'b0} >= {1'b0, depth_entries});
    wire        event_nonempty_flag = (count_r != 6'h00);
    wire [3:0]  flags = {event_overflow_flag_r, event_full_flag,
                         event_half_flag, event_nonempty_flag};
    wire [31:0] entry_size = event_timestamp_enable_r ?
                             EVQ_STRIDE + EVQ_TS_XTRA : EVQ_STRIDE;
    wire [31:0] tail_addr  = EVQ_BASE + {27'h0, tail_r} * entry_size;
    wire [31:0] head_addr  = EVQ_BASE + {27'h0, head_r} * entry_size;

    wire wr_ctl   = reg_wr_i && (reg_addr_i == `CTEQ_REG_CONTROL);
    wire tail_inc = wr_ctl && reg_wdata_i[`CTEQ_TAIL_INC_BIT]
                    && event_nonempty_flag && !queue_reset_request_r;
    wire push     = tx_done_log_i && !event_full_flag && !queue_reset_request_r;
    wire ovf_evt  = tx_done_log_i && event_full_flag && !queue_reset_request_r;

    wire [4:0] depth_last = queue_depth_field_r;
    wire [2:0] rd_mq = reg_addr_i[2:0] - 3'h1;
    wire       rd_mq_hit = (reg_addr_i[`CTEQ_ADDR_W-1:4] == 1'b0) &&
                           (reg_addr_i[3] == 1'b1) && (reg_addr_i[2:0] != 3'h0);

    assign mq_sel_o = mq_sel_r;

    // Message queue pointer select follows the address of every register read or write
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            mq_sel_r <= 3'h0;
        else if (reg_wr_i || reg_rd_i)
            mq_sel_r <= rd_mq;
    end

    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            queue_depth_field_r      <= `CTEQ_DEPTH_RESET;
            event_timestamp_enable_r <= 1'b0;
            irq_enable_r             <= `CTEQ_IE_RESET;
            event_overflow_flag_r    <= 1'b0;
            queue_reset_request_r    <= 1'b0;
            mode_r                   <= `CTEQ_MODE_RESET;
            queue_direction_select_r <= {MQ_COUNT{1'b0}};
            head_r                   <= 5'h00;
            tail_r                   <= 5'h00;
            count_r                  <= 6'h00;
        end
        else
        begin
            if (reg_wr_i && reg_addr_i == `CTEQ_REG_DEPTH_CFG && in_config)
                queue_depth_field_r <= reg_wdata_i[`CTEQ_DEPTH_MSB:`CTEQ_DEPTH_LSB];
            if (wr_ctl)
            begin
                if (in_config)
                    event_timestamp_enable_r <= reg_wdata_i[`CTEQ_TS_EN_BIT];
                irq_enable_r <= reg_wdata_i[3:0];
            end
            if (reg_wr_i && reg_addr_i == `CTEQ_REG_MODE)
                mode_r <= reg_wdata_i[2:0];
            if (reg_wr_i && reg_addr_i == `CTEQ_REG_MQ_DIR)
                queue_direction_select_r <= reg_wdata_i[MQ_COUNT-1:0];
            // Overflow: set wins over a software clear in the same cycle
            if (ovf_evt)
                event_overflow_flag_r <= 1'b1;
            else if (reg_wr_i && reg_addr_i == `CTEQ_REG_STATUS &&
                     !reg_wdata_i[`CTEQ_OVF_BIT])
                event_overflow_flag_r <= 1'b0;
            // Reset takes one cycle, control reads one until done
            if (queue_reset_request_r)
            begin
                head_r                <= 5'h00;
                tail_r                <= 5'h00;
                count_r               <= 6'h00;
                event_overflow_flag_r <= 1'b0;
                queue_reset_request_r <= 1'b0;
            end
            else
            begin
                if (wr_ctl && reg_wdata_i[`CTEQ_RESET_BIT])
                    queue_reset_request_r <= 1'b1;
                if (push)
                    head_r <= (head_r >= depth_last) ? 5'h00 : head_r + 5'h01;
                if (tail_inc)
                    tail_r <= (tail_r >= depth_last) ? 5'h00 : tail_r + 5'h01;
                if (push && !tail_inc)
                    count_r <= count_r + 6'h01;
                else if (tail_inc && !push)
                    count_r <= count_r - 6'h01;
            end
        end
    end

    // Outputs to the entry writer and interrupt line
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            controller_operating_mode_o <= `CTEQ_MODE_RESET;
            event_timestamp_enable_o    <= 1'b0;
            evq_write_stb_o             <= 1'b0;
            evq_write_addr_o            <= 32'h0;
            evq_irq_o                   <= 1'b0;
        end
        else
        begin
            controller_operating_mode_o <= mode_r;
            event_timestamp_enable_o    <= event_timestamp_enable_r;
            evq_write_stb_o             <= push;
            evq_write_addr_o            <= head_addr;
            evq_irq_o                   <= |(flags & irq_enable_r);
        end
    end

    // Read data, one cycle after the strobe
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            reg_rdata_o <= 16'h0000;
        else if (reg_rd_i)
        begin
            reg_rdata_o <= 16'h0000;
            case (reg_addr_i)
                `CTEQ_REG_DEPTH_CFG: reg_rdata_o <= {3'h0, queue_depth_field_r, 8'h00};
                `CTEQ_REG_CONTROL:   reg_rdata_o <= {5'h00, queue_reset_request_r, 4'h0,
                                                     event_timestamp_enable_r, 1'b0,
                                                     irq_enable_r};
                `CTEQ_REG_STATUS:    reg_rdata_o <= {12'h000, flags};
                `CTEQ_REG_EVQ_UA_HI: reg_rdata_o <= tail_addr[31:16];
                `CTEQ_REG_EVQ_UA_LO: reg_rdata_o <= tail_addr[15:0];
                `CTEQ_REG_MODE:      reg_rdata_o <= {13'h0000, mode_r};
                `CTEQ_REG_MQ_DIR:    reg_rdata_o <= {{(16-MQ_COUNT){1'b0}},
                                                     queue_direction_select_r};
                default:             reg_rdata_o <= 16'h0000;
            endcase
            if (rd_mq_hit)
                reg_rdata_o <= queue_direction_select_r[rd_mq] ?
                               mq_head_addr_i[15:0] :
                               mq_tail_addr_i[15:0];
            // High words sit at 0x11..0x17, one per queue
            if ((reg_addr_i[`CTEQ_ADDR_W-1:3] == 2'b10) && (reg_addr_i[2:0] != 3'h0))
                reg_rdata_o <= queue_direction_select_r[rd_mq] ?
                               mq_head_addr_i[31:16] :
                               mq_tail_addr_i[31:16];
        end
    end
endmodule // cteq_top

// File: cteq_chk.sv
`timescale 1ns/100ps
`include "cteq_defines.vh"
module cteq_chk #(
    parameter EVQ_BASE    = 32'h0000_0400,
    parameter EVQ_STRIDE  = 32'h0000_0010,
    parameter EVQ_TS_XTRA = 32'h0000_0004,
    parameter MQ_COUNT    = 7
) (
    input wire                    ref_clk_i,
    input wire                    sys_rst_i,
    input wire [`CTEQ_ADDR_W-1:0] reg_addr_i,
    input wire [15:0]             reg_wdata_i,
    input wire                    reg_wr_i,
    input wire                    reg_rd_i,
    input wire [15:0]             reg_rdata_o,
    input wire                    tx_done_log_i,
    input wire [2:0]              controller_operating_mode_o,
    input wire                    event_timestamp_enable_o,
    input wire                    evq_write_stb_o,
    input wire [31:0]             evq_write_addr_o,
    input wire                    evq_irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_status_top_zero: assert property (
        $past(reg_rd_i && reg_addr_i == `CTEQ_REG_STATUS) |-> reg_rdata_o[15:4] == 12'h000)
        else $error("status upper bits not zero");
    a_flag_nesting: assert property (
        $past(reg_rd_i && reg_addr_i == `CTEQ_REG_STATUS)
        |-> reg_rdata_o[2:0] inside {3'h0, 3'h1, 3'h3, 3'h7})
        else $error("occupancy flags inconsistent");
    a_irq_masked: assert property (
        reg_wr_i && reg_addr_i == `CTEQ_REG_CONTROL && reg_wdata_i[3:0] == 4'h0 ##1 !reg_wr_i
        |=> !evq_irq_o) else $error("interrupt with all enables off");
    a_push_cause: assert property (
        evq_write_stb_o |-> $past(tx_done_log_i)) else $error("entry write without event");
    a_entry_align: assert property (
        evq_write_stb_o |-> evq_write_addr_o >= EVQ_BASE && (evq_write_addr_o - EVQ_BASE)
        % (EVQ_STRIDE + (event_timestamp_enable_o ? EVQ_TS_XTRA : 32'h0)) == 32'h0)
        else $error("entry address off grid");
    a_ts_cfg_only: assert property (
        $changed(event_timestamp_enable_o) |-> $past(reg_wr_i && reg_addr_i ==
        `CTEQ_REG_CONTROL, 2) && $past(controller_operating_mode_o) == `CTEQ_MODE_CONFIG)
        else $error("timestamp enable changed outside config write");
    a_mode_by_write: assert property (
        $changed(controller_operating_mode_o) |-> $past(reg_wr_i && reg_addr_i ==
        `CTEQ_REG_MODE, 2)) else $error("mode changed without write");
    a_reset_values: assert property (disable iff (1'b0)
        sys_rst_i |=> controller_operating_mode_o == `CTEQ_MODE_RESET && !evq_irq_o
        && !event_timestamp_enable_o && !evq_write_stb_o) else $error("bad reset values");
    c_overflow: cover property ($past(reg_rd_i && reg_addr_i == `CTEQ_REG_STATUS)
        && reg_rdata_o[3]);
    c_ts_push: cover property (evq_write_stb_o && event_timestamp_enable_o);
    c_irq: cover property (evq_irq_o);
endmodule // cteq_chk

bind cteq_top cteq_chk #(.EVQ_BASE(EVQ_BASE), .EVQ_STRIDE(EVQ_STRIDE),
    .EVQ_TS_XTRA(EVQ_TS_XTRA), .MQ_COUNT(MQ_COUNT)) u_chk (.*);

// File: cteq_top_bench.sv
`timescale 1ns/100ps
`include "cteq_defines.vh"
module cteq_top_bench;
    logic        ref_clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic        tx_done_log_i = 1'b0;
    logic [4:0]  reg_addr_i = 5'h00;
    logic [15:0] reg_wdata_i = 16'h0000, got;
    logic [31:0] mq_head_addr_i = 32'h1234_5678, mq_tail_addr_i = 32'h9abc_def0;
    wire  [15:0] reg_rdata_o;
    wire  [2:0]  controller_operating_mode_o, mq_sel_o;
    wire         event_timestamp_enable_o, evq_write_stb_o, evq_irq_o;
    wire  [31:0] evq_write_addr_o;
    logic [15:0] occ [0:3] = '{16'h0001, 16'h0003, 16'h0003, 16'h0007};
    int          err_count = 0, checked = 0, i;
    cteq_top dut (.*);
    initial forever #50 ref_clk_i = ~ref_clk_i;
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask
    task wreg(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task rreg(input logic [4:0] a, input logic [15:0] e, input bit c = 1'b1);
        @(posedge ref_clk_i);
        {reg_rd_i, reg_addr_i} <= {1'b1, a};
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 got = reg_rdata_o;
        if (c) chk($sformatf("register %h", a), {16'h0, e}, {16'h0, got});
    endtask
    task push(input logic s, input logic [31:0] ea);
        @(posedge ref_clk_i);
        tx_done_log_i <= 1'b1;
        @(posedge ref_clk_i);
        tx_done_log_i <= 1'b0;
        #1 chk("entry strobe", {31'h0, s}, {31'h0, evq_write_stb_o});
        if (s) chk("entry address", ea, evq_write_addr_o);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #2000000;
        err_count++;
        report_and_stop;
    end
    initial
    begin
        repeat (10) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        rreg(`CTEQ_REG_DEPTH_CFG, 16'h0000);
        rreg(`CTEQ_REG_CONTROL, 16'h0000);
        rreg(`CTEQ_REG_STATUS, 16'h0000);
        wreg(`CTEQ_REG_DEPTH_CFG, 16'h0300);
        wreg(`CTEQ_REG_CONTROL, 16'h0020);
        wreg(`CTEQ_REG_MODE, 16'h0000);
        wreg(`CTEQ_REG_DEPTH_CFG, 16'h1f00);
        wreg(`CTEQ_REG_CONTROL, 16'h000f);
        rreg(`CTEQ_REG_DEPTH_CFG, 16'h0300);
        rreg(`CTEQ_REG_CONTROL, 16'h002f);
        $display("config test done");
        for (i = 0; i < 4; i++)
        begin
            push(1'b1, 32'h0000_0400 + i * 32'h14);
            rreg(`CTEQ_REG_STATUS, occ[i]);
        end
        chk("irq", 32'h1, {31'h0, evq_irq_o});
        push(1'b0, 32'h0);
        rreg(`CTEQ_REG_STATUS, 16'h000f);
        wreg(`CTEQ_REG_STATUS, 16'hfff0);
        rreg(`CTEQ_REG_STATUS, 16'h0007);
        rreg(`CTEQ_REG_EVQ_UA_HI, 16'h0000);
        rreg(`CTEQ_REG_EVQ_UA_LO, 16'h0400);
        wreg(`CTEQ_REG_CONTROL, 16'h012f);
        rreg(`CTEQ_REG_EVQ_UA_LO, 16'h0414);
        rreg(`CTEQ_REG_STATUS, 16'h0003);
        wreg(`CTEQ_REG_CONTROL, 16'h002f);
        rreg(`CTEQ_REG_EVQ_UA_LO, 16'h0414);
        wreg(`CTEQ_REG_CONTROL, 16'h042f);
        got = 16'h0400;
        for (i = 0; i < 20 && got[10] !== 1'b0; i++)
            rreg(`CTEQ_REG_CONTROL, 16'h0, 1'b0);
        chk("reset request", 32'h0, {31'h0, got[10]});
        rreg(`CTEQ_REG_STATUS, 16'h0000);
        wreg(`CTEQ_REG_CONTROL, 16'h0020);
        push(1'b1, 32'h0000_0400);
        chk("irq masked", 32'h0, {31'h0, evq_irq_o});
        wreg(`CTEQ_REG_CONTROL, 16'h0021);
        rreg(`CTEQ_REG_STATUS, 16'h0001);
        chk("irq enabled", 32'h1, {31'h0, evq_irq_o});
        $display("event queue test done");
        wreg(`CTEQ_REG_MQ_DIR, 16'h0055);
        for (i = 1; i < 8; i++)
        begin
            rreg(5'(`CTEQ_REG_MQ_UA_BASE + i + 8), i[0] ? mq_head_addr_i[31:16]
                : mq_tail_addr_i[31:16]);
            rreg(5'(`CTEQ_REG_MQ_UA_BASE + i), i[0] ? mq_head_addr_i[15:0]
                : mq_tail_addr_i[15:0]);
            chk("queue select", i - 1, {29'h0, mq_sel_o});
        end
        $display("user pointer test done");
        report_and_stop;
    end
endmodule // cteq_top_bench
